// ===== rpg_pkg.sv
// Constants shared by the RF password access guard and its retry counters.
package rpg_pkg;

  // Capability container location and delivery contents, byte 0 in the LSBs.
  localparam logic [7:0]  RPG_CC_BLK       = 8'h03;
  localparam logic [31:0] RPG_CC_RST_LARGE = 32'h003B10E1;
  localparam logic [31:0] RPG_CC_RST_SMALL = 32'h001B10E1;

  // Kill byte layout.
  localparam logic [7:0]  RPG_KILL_RST     = 8'h00;
  localparam int          RPG_KILL_RF_BIT  = 6;
  localparam int          RPG_KILL_TUN_BIT = 7;

  // Retry byte layout: primary in b2..b0, copy in b6..b4.
  localparam int          RPG_RETRY_W      = 3;
  localparam int          RPG_RETRY_P_LSB  = 0;
  localparam int          RPG_RETRY_C_LSB  = 4;
  localparam logic [2:0]  RPG_RETRY_FULL   = 3'h7;
  localparam logic [2:0]  RPG_RETRY_ZERO   = 3'h0;
  localparam logic [2:0]  RPG_RETRY_STEP   = 3'h1;
  localparam logic [7:0]  RPG_RETRY_RST    = 8'h77;

  // Protection limit and option bytes.
  localparam logic [7:0]  RPG_LIMIT_RST    = 8'hFF;
  localparam logic [7:0]  RPG_OPT_RST      = 8'h00;
  localparam int          RPG_OPT_R_BIT    = 0;
  localparam int          RPG_OPT_W_BIT    = 1;

  // Sense reply high byte and password reset contents.
  localparam logic [7:0]  RPG_SENSE_HI_RST = 8'h00;
  localparam logic [31:0] RPG_PWD_RST      = 32'h00000000;

  // Default geometry: password block and last implemented block.
  localparam logic [7:0]  RPG_PWD_BLK_DEF  = 8'h2B;
  localparam logic [7:0]  RPG_LAST_BLK_DEF = 8'h7F;
  localparam int          RPG_READ_SPAN    = 4;

  // Configuration byte index on the host port and the RF config port.
  localparam logic [3:0]  RPG_CFG_KILL     = 4'h0;
  localparam logic [3:0]  RPG_CFG_RETRY    = 4'h1;
  localparam logic [3:0]  RPG_CFG_LIMIT    = 4'h2;
  localparam logic [3:0]  RPG_CFG_OPT      = 4'h3;
  localparam logic [3:0]  RPG_CFG_SENSE_HI = 4'h4;
  localparam logic [3:0]  RPG_CFG_PWD0     = 4'h5;
  localparam logic [3:0]  RPG_CFG_PWD3     = 4'h8;
  localparam logic [3:0]  RPG_CFG_CC0      = 4'h9;
  localparam logic [3:0]  RPG_CFG_CC3      = 4'hC;

  localparam logic [7:0]  RPG_BYTE_ZERO    = 8'h00;

  // RF request kinds, one-hot.
  typedef enum logic [3:0] {
    RPG_OP_READ   = 4'b0001,
    RPG_OP_WRITE  = 4'b0010,
    RPG_OP_CFG_RD = 4'b0100,
    RPG_OP_CFG_WR = 4'b1000
  } rpg_op_e;

endpackage

// ===== rpg_retry.sv
// Duplicated authentication retry counters with lockout detection.
`timescale 1ns/10ps
module rpg_retry
  import rpg_pkg::*;
(
  input  wire logic       clk_sys,     // System clock.
  input  wire logic       arst_n,      // Asynchronous reset, active low.
  input  wire logic       host_we,     // Host writes the retry byte.
  input  wire logic [7:0] host_wdata,  // Host write data.
  input  wire logic       auth_pass,   // Successful RF authentication.
  input  wire logic       auth_fail,   // Failed RF authentication.
  output logic      [7:0] retry_reg,   // Stored retry byte.
  output logic            locked       // RF authentication is blocked.
);

  logic [2:0] retry_counter_primary;
  logic [2:0] retry_counter_copy;

  assign retry_counter_primary = retry_reg[RPG_RETRY_P_LSB +: RPG_RETRY_W];
  assign retry_counter_copy    = retry_reg[RPG_RETRY_C_LSB +: RPG_RETRY_W];

  assign locked = (retry_counter_primary == RPG_RETRY_ZERO) ||
                  (retry_counter_primary != retry_counter_copy);

  // RF events win over a host write in the same cycle so no attempt is lost.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      retry_reg <= RPG_RETRY_RST;
    end else if (auth_pass) begin
      retry_reg <= RPG_RETRY_RST;
    end else if (auth_fail) begin
      retry_reg[RPG_RETRY_P_LSB +: RPG_RETRY_W] <=
        retry_counter_primary - RPG_RETRY_STEP;
      retry_reg[RPG_RETRY_C_LSB +: RPG_RETRY_W] <=
        retry_counter_copy - RPG_RETRY_STEP;
    end else if (host_we) begin
      retry_reg <= host_wdata;
    end
  end

  // Counters always move together after an RF event.
  property p_retry_pair;
    @(posedge clk_sys) disable iff (!arst_n)
    (auth_fail && !auth_pass && !locked) |=>
      (retry_counter_primary ==
       $past(retry_counter_primary) - RPG_RETRY_STEP) &&
      (retry_counter_copy == retry_counter_primary);
  endproperty
  a_retry_pair: assert property (p_retry_pair)
    else $error("retry copies did not decrement together");

  property p_retry_reload;
    @(posedge clk_sys) disable iff (!arst_n)
    auth_pass |=> (retry_counter_primary == RPG_RETRY_FULL) && !locked;
  endproperty
  a_retry_reload: assert property (p_retry_reload)
    else $error("retry counters not reloaded to seven");

endmodule

// ===== rpg_guard.sv
// RF side password, lock and kill access guard for the tag memory.
// Summary of operation
// - Capability container RF writes OR into content.
// - Container delivery value depends on memory size.
// - Matching password write enters authenticated state.
// - Wrong password: silent, to sleep, count down.
// - RF password change only while authenticated.
// - Leaving selected state drops authentication.
// - Reading password block returns zeroes.
// - Lock bits override authentication for writes.
// - Host access never restricted by password.
// - Kill bits disable RF and tunneling until host clears them.
// - Kill byte resets zero, host only.
// - Two retry counters, copy mirrors primary.
// - Success reloads seven, failure decrements.
// - Zero or mismatch blocks authentication until host.
// - Limit byte marks last unprotected block.
// - Limit past memory end disables protection.
// - Only protected blocks accessed: no response.
// - Mixed access zeroes protected blocks only.
// - Option bits select read and write protection.
// - RF limit/options need authentication and permission.
// - Sense reply high byte RF gated by enable.
`timescale 1ns/10ps
module rpg_guard
  import rpg_pkg::*;
#(
  parameter logic [7:0] PWD_BLK   = RPG_PWD_BLK_DEF,  // Password block.
  parameter logic [7:0] LAST_BLK  = RPG_LAST_BLK_DEF, // Last memory block.
  parameter bit         LARGE_MEM = 1'b1              // Larger memory option.
)
(
  input  wire logic        clk_sys,          // System clock, 200 MHz.
  input  wire logic        arst_n,           // Async reset, active low.
  input  wire logic        rf_req,           // RF request strobe.
  input  wire rpg_op_e     rf_op,            // RF request kind.
  input  wire logic [7:0]  rf_addr,          // Block address.
  input  wire logic [3:0]  rf_cfg_idx,       // Config byte index.
  input  wire logic [31:0] rf_wdata,         // Write data, byte 0 low.
  input  wire logic        rf_selected,      // Tag is in selected state.
  input  wire logic        rf_lock_hit,      // Addressed block is locked.
  input  wire logic        rfcfg_en,         // RF config permission.
  input  wire logic        auth_set,         // RF auth setting permission.
  input  wire logic        host_req,         // Host access strobe.
  input  wire logic        host_we,          // Host write when high.
  input  wire logic [3:0]  host_idx,         // Host config byte index.
  input  wire logic [7:0]  host_wdata,       // Host write data.
  output logic      [7:0]  host_rdata,       // Host read data.
  output logic             rf_done,          // RF answer ready pulse.
  output logic             rf_ack,           // Request accepted.
  output logic             rf_mute,          // Send no reply.
  output logic             rf_sleep,         // Drop to sense or sleep.
  output logic      [3:0]  rf_zero_mask,     // Blocks to read as zero.
  output logic      [7:0]  rf_cfg_rdata,     // RF config read data.
  output logic             eep_wr,           // Memory write strobe.
  output logic             rf_authenticated, // Authenticated state.
  output logic             rf_disabled,      // RF part killed.
  output logic             tunnel_disabled,  // Tunneling modes killed.
  output logic      [7:0]  sense_reply_high, // Sense reply bits 15..8.
  output logic      [31:0] cc_value          // Capability container.
);

  logic [7:0]  kill_switch_reg;
  logic [7:0]  protect_limit_reg;
  logic [7:0]  protect_options_reg;
  logic [7:0]  sense_reply_high_reg;
  logic [31:0] password_reg;
  logic [31:0] capability_container_reg;
  logic [7:0]  retry_counters_reg;
  logic        retry_locked;
  logic        auth_reg;

  logic        done_next, ack_next, mute_next, sleep_next, wr_next;
  logic [3:0]  zero_next;
  logic [7:0]  cfg_rd_next;
  logic        pass_now, fail_now, pwd_set_now, cc_or_now;
  logic        limit_wr_now, opt_wr_now, sense_wr_now;
  logic        host_wr;
  logic [3:0]  blk_prot;
  logic [3:0]  blk_pwd;
  logic        killed;
  logic        lim_active;
  logic        cfg_ok;

  // Byte select of a 32-bit word by a config index offset.
  function automatic logic [7:0] word_byte(input logic [31:0] w,
                                           input logic [1:0]  sel);
    word_byte = w[{sel, 3'b000} +: 8];
  endfunction

  // A block is guarded when protection is active, its option bit is set, no session is authenticated and it sits above limit.
  function automatic logic is_prot(input logic [7:0] blk,
                                   input logic       need,
                                   input logic [7:0] lim,
                                   input logic       act,
                                   input logic       auth);
    is_prot = act && need && !auth && (blk > lim);
  endfunction

  assign host_wr = host_req && host_we;
  assign killed  = kill_switch_reg[RPG_KILL_RF_BIT];
  assign lim_active = (protect_limit_reg < LAST_BLK);

  // Per-block read protection over the four blocks a read returns.
  for (genvar i = 0; i < RPG_READ_SPAN; i++) begin : g_span
    logic [7:0] blk;
    assign blk = rf_addr + 8'(i);
    assign blk_prot[i] = is_prot(blk, protect_options_reg[RPG_OPT_R_BIT],
                                 protect_limit_reg, lim_active, auth_reg);
    assign blk_pwd[i]  = (blk == PWD_BLK);
  end

  always_comb begin
    cfg_ok = 1'b0;
    if (rf_cfg_idx == RPG_CFG_LIMIT || rf_cfg_idx == RPG_CFG_OPT) begin
      cfg_ok = auth_reg && auth_set;
    end else if (rf_cfg_idx == RPG_CFG_SENSE_HI) begin
      cfg_ok = rfcfg_en;
    end
  end

  // Decide the answer to one RF request; kill outranks everything else.
  always_comb begin
    done_next    = rf_req;
    ack_next     = 1'b0;
    mute_next    = 1'b0;
    sleep_next   = 1'b0;
    wr_next      = 1'b0;
    zero_next    = 4'h0;
    cfg_rd_next  = RPG_BYTE_ZERO;
    pass_now     = 1'b0;
    fail_now     = 1'b0;
    pwd_set_now  = 1'b0;
    cc_or_now    = 1'b0;
    limit_wr_now = 1'b0;
    opt_wr_now   = 1'b0;
    sense_wr_now = 1'b0;
    if (rf_req) begin
      if (killed) begin
        mute_next = 1'b1;
      end else begin
        unique case (rf_op)
          RPG_OP_READ: begin
            if (&blk_prot) begin
              mute_next = 1'b1;
            end else begin
              ack_next  = 1'b1;
              zero_next = blk_prot | blk_pwd;
            end
          end
          RPG_OP_WRITE: begin
            if (rf_addr == PWD_BLK) begin
              if (auth_reg) begin
                ack_next    = 1'b1;
                pwd_set_now = 1'b1;
              end else if (retry_locked) begin
                mute_next = 1'b1;
              end else if (rf_wdata == password_reg) begin
                ack_next = 1'b1;
                pass_now = rf_selected;
              end else begin
                mute_next  = 1'b1;
                sleep_next = 1'b1;
                fail_now   = 1'b1;
              end
            end else if (rf_lock_hit) begin
              ack_next = 1'b0;
            end else if (is_prot(rf_addr,
                                 protect_options_reg[RPG_OPT_W_BIT],
                                 protect_limit_reg, lim_active,
                                 auth_reg)) begin
              mute_next = 1'b1;
            end else if (rf_addr == RPG_CC_BLK) begin
              ack_next  = 1'b1;
              cc_or_now = 1'b1;
            end else begin
              ack_next = 1'b1;
              wr_next  = 1'b1;
            end
          end
          RPG_OP_CFG_RD: begin
            // kill and retry never visible to RF
            ack_next = cfg_ok;
            if (cfg_ok) begin
              unique case (rf_cfg_idx)
                RPG_CFG_LIMIT: cfg_rd_next = protect_limit_reg;
                RPG_CFG_OPT:   cfg_rd_next = protect_options_reg;
                default:       cfg_rd_next = sense_reply_high_reg;
              endcase
            end
          end
          RPG_OP_CFG_WR: begin
            ack_next     = cfg_ok;
            limit_wr_now = cfg_ok && (rf_cfg_idx == RPG_CFG_LIMIT);
            opt_wr_now   = cfg_ok && (rf_cfg_idx == RPG_CFG_OPT);
            sense_wr_now = cfg_ok && (rf_cfg_idx == RPG_CFG_SENSE_HI);
          end
          default: mute_next = 1'b1;
        endcase
      end
    end
  end

  // Registered RF answer; every output holds a flip-flop.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rf_done      <= 1'b0;
      rf_ack       <= 1'b0;
      rf_mute      <= 1'b0;
      rf_sleep     <= 1'b0;
      rf_zero_mask <= 4'h0;
      rf_cfg_rdata <= RPG_BYTE_ZERO;
      eep_wr       <= 1'b0;
    end else begin
      rf_done      <= done_next;
      rf_ack       <= ack_next;
      rf_mute      <= mute_next;
      rf_sleep     <= sleep_next;
      rf_zero_mask <= zero_next;
      rf_cfg_rdata <= cfg_rd_next;
      eep_wr       <= wr_next;
    end
  end

  // Authentication state; deselection wins so a stale session never lives.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      auth_reg <= 1'b0;
    end else if (!rf_selected) begin
      auth_reg <= 1'b0;
    end else if (pass_now) begin
      auth_reg <= 1'b1;
    end
  end

  // host writes, never gated by authentication
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      kill_switch_reg <= RPG_KILL_RST;
    end else if (host_wr && host_idx == RPG_CFG_KILL) begin
      kill_switch_reg <= host_wdata;
    end
  end

  // Protection bytes: RF writes arrive only with permission.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      protect_limit_reg    <= RPG_LIMIT_RST;
      protect_options_reg  <= RPG_OPT_RST;
      sense_reply_high_reg <= RPG_SENSE_HI_RST;
    end else begin
      if (limit_wr_now) begin
        protect_limit_reg <= rf_wdata[7:0];
      end else if (host_wr && host_idx == RPG_CFG_LIMIT) begin
        protect_limit_reg <= host_wdata;
      end
      if (opt_wr_now) begin
        protect_options_reg <= rf_wdata[7:0];
      end else if (host_wr && host_idx == RPG_CFG_OPT) begin
        protect_options_reg <= host_wdata;
      end
      if (sense_wr_now) begin
        sense_reply_high_reg <= rf_wdata[7:0];
      end else if (host_wr && host_idx == RPG_CFG_SENSE_HI) begin
        sense_reply_high_reg <= host_wdata;
      end
    end
  end

  // Password and container; host byte writes are unrestricted.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      password_reg <= RPG_PWD_RST;
      capability_container_reg <= LARGE_MEM ? RPG_CC_RST_LARGE
                                            : RPG_CC_RST_SMALL;
    end else begin
      if (pwd_set_now) begin
        password_reg <= rf_wdata;
      end else if (host_wr && host_idx >= RPG_CFG_PWD0 &&
                   host_idx <= RPG_CFG_PWD3) begin
        password_reg[{2'(host_idx - RPG_CFG_PWD0), 3'b000} +: 8] <=
          host_wdata;
      end
      if (cc_or_now) begin
        capability_container_reg <= capability_container_reg | rf_wdata;
      end else if (host_wr && host_idx >= RPG_CFG_CC0 &&
                   host_idx <= RPG_CFG_CC3) begin
        capability_container_reg[{2'(host_idx - RPG_CFG_CC0), 3'b000} +: 8]
          <= host_wdata;
      end
    end
  end

  // Host read data, registered one cycle after the strobe.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata <= RPG_BYTE_ZERO;
    end else if (host_req && !host_we) begin
      if (host_idx >= RPG_CFG_CC0 && host_idx <= RPG_CFG_CC3) begin
        host_rdata <= word_byte(capability_container_reg,
                                2'(host_idx - RPG_CFG_CC0));
      end else if (host_idx >= RPG_CFG_PWD0 && host_idx <= RPG_CFG_PWD3) begin
        host_rdata <= word_byte(password_reg, 2'(host_idx - RPG_CFG_PWD0));
      end else begin
        unique case (host_idx)
          RPG_CFG_KILL:     host_rdata <= kill_switch_reg;
          RPG_CFG_RETRY:    host_rdata <= retry_counters_reg;
          RPG_CFG_LIMIT:    host_rdata <= protect_limit_reg;
          RPG_CFG_OPT:      host_rdata <= protect_options_reg;
          RPG_CFG_SENSE_HI: host_rdata <= sense_reply_high_reg;
          default:          host_rdata <= RPG_BYTE_ZERO;
        endcase
      end
    end
  end

  rpg_retry u_retry (
    .clk_sys    (clk_sys),
    .arst_n     (arst_n),
    .host_we    (host_wr && host_idx == RPG_CFG_RETRY),
    .host_wdata (host_wdata),
    .auth_pass  (pass_now),
    .auth_fail  (fail_now),
    .retry_reg  (retry_counters_reg),
    .locked     (retry_locked)
  );

  assign rf_authenticated = auth_reg;
  assign rf_disabled      = kill_switch_reg[RPG_KILL_RF_BIT];
  assign tunnel_disabled  = kill_switch_reg[RPG_KILL_TUN_BIT];
  assign sense_reply_high = sense_reply_high_reg;
  assign cc_value         = capability_container_reg;

  property p_cc_or;
    @(posedge clk_sys) disable iff (!arst_n)
    (rf_req && rf_op == RPG_OP_WRITE && rf_addr == RPG_CC_BLK && !killed &&
     !rf_lock_hit && ack_next) |=>
      cc_value == ($past(cc_value) | $past(rf_wdata)) && rf_ack;
  endproperty
  a_cc_or: assert property (p_cc_or)
    else $error("container write was not an OR");

  property p_auth_ok;
    @(posedge clk_sys) disable iff (!arst_n)
    (rf_req && rf_op == RPG_OP_WRITE && rf_addr == PWD_BLK && !killed &&
     !auth_reg && !retry_locked && rf_wdata == password_reg && rf_selected)
      |=> rf_authenticated && rf_ack && rf_done;
  endproperty
  a_auth_ok: assert property (p_auth_ok)
    else $error("matching password did not authenticate");

  property p_auth_bad;
    @(posedge clk_sys) disable iff (!arst_n)
    (rf_req && rf_op == RPG_OP_WRITE && rf_addr == PWD_BLK && !killed &&
     !auth_reg && !retry_locked && rf_wdata != password_reg)
      |=> rf_mute && rf_sleep && !rf_authenticated &&
          retry_counters_reg != $past(retry_counters_reg);
  endproperty
  a_auth_bad: assert property (p_auth_bad)
    else $error("wrong password not silenced and counted");

  property p_deselect;
    @(posedge clk_sys) disable iff (!arst_n)
    !rf_selected |=> !rf_authenticated;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("authentication survived deselection");

  property p_pwd_zero;
    @(posedge clk_sys) disable iff (!arst_n)
    (rf_req && rf_op == RPG_OP_READ && rf_addr == PWD_BLK && !killed)
      |=> rf_mute || rf_zero_mask[0];
  endproperty
  a_pwd_zero: assert property (p_pwd_zero)
    else $error("password block read not zeroed");

  property p_lock_wins;
    @(posedge clk_sys) disable iff (!arst_n)
    (rf_req && rf_op == RPG_OP_WRITE && rf_lock_hit && rf_addr != PWD_BLK)
      |=> !rf_ack && !eep_wr && $stable(cc_value);
  endproperty
  a_lock_wins: assert property (p_lock_wins)
    else $error("locked block was written");

  property p_kill;
    @(posedge clk_sys) disable iff (!arst_n)
    (rf_req && killed) |=> rf_mute && !rf_ack && !eep_wr;
  endproperty
  a_kill: assert property (p_kill)
    else $error("killed RF part answered");

  property p_lockout;
    @(posedge clk_sys) disable iff (!arst_n)
    (rf_req && rf_op == RPG_OP_WRITE && rf_addr == PWD_BLK && retry_locked &&
     !auth_reg) |=> !rf_authenticated && rf_mute;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("authentication passed while locked out");

  property p_host_kill;
    @(posedge clk_sys) disable iff (!arst_n)
    (host_wr && host_idx == RPG_CFG_KILL) |=>
      rf_disabled == $past(host_wdata[RPG_KILL_RF_BIT]);
  endproperty
  a_host_kill: assert property (p_host_kill)
    else $error("host kill write not taken");

  c_auth: cover property (@(posedge clk_sys) disable iff (!arst_n)
    !rf_authenticated ##1 rf_authenticated);
  c_mixed: cover property (@(posedge clk_sys) disable iff (!arst_n)
    rf_ack && rf_zero_mask != 4'h0 && rf_zero_mask != 4'hF);
  c_lockout: cover property (@(posedge clk_sys) disable iff (!arst_n)
    retry_locked && rf_mute);

endmodule

// ===== rpg_reader.sv
// Reader model that issues requests on the RF side of the guard.
`timescale 1ns/10ps
module rpg_reader
  import rpg_pkg::*;
(
  input  wire logic        clk_sys,    // System clock.
  input  wire logic        rf_done,    // Answer strobe.
  input  wire logic [6:0]  ans,        // Ack, mute, sleep, zero mask.
  output rpg_op_e          rf_op,      // Request kind.
  output logic             rf_req,     // Request strobe.
  output logic      [7:0]  rf_addr,    // Block address or config index.
  output logic      [31:0] rf_wdata,   // Write data.
  output logic      [6:0]  resp        // Answer seen with rf_done.
);
  int n;

  // Idle request lines from time zero so no unknown reaches the guard.
  initial begin
    rf_req   = 1'b0;
    rf_op    = RPG_OP_READ;
    rf_addr  = 8'h00;
    rf_wdata = 32'h0000_0000;
  end

  // Address and data lines are inverted after use so stale values are never mistaken.
  task automatic send(input rpg_op_e op, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk_sys);
    rf_req   <= 1'b1;
    rf_op    <= op;
    rf_addr  <= a;
    rf_wdata <= d;
    @(posedge clk_sys);
    rf_req   <= 1'b0;
    rf_addr  <= ~a;
    rf_wdata <= ~d;
    #1;
    for (n = 0; n < 4 && rf_done !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    resp = ans;
  endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the RF password access guard.
`timescale 1ns/10ps
module tb_top
  import rpg_pkg::*;
;
  logic        clk_sys, arst_n, rf_selected, rf_lock_hit, rf_req;
  logic        host_req, host_we, rf_done, rf_ack, rf_mute, rf_sleep;
  logic        rf_auth, rf_dis, rf_cfg_en, auth_set, eep_wr, tun_dis;
  logic [3:0]  host_idx, rf_zero_mask;
  logic [7:0]  host_wdata, host_rdata, rf_addr, cfg_rdata, sense_hi;
  logic [31:0] rf_wdata, cc_value;
  logic [6:0]  resp;
  rpg_op_e     rf_op;
  int          num_errors = 0, cmp_count = 0, cycles = 0;

  rpg_guard DUT (.clk_sys(clk_sys), .arst_n(arst_n), .rf_req(rf_req),
    .rf_op(rf_op), .rf_addr(rf_addr), .rf_cfg_idx(rf_addr[3:0]),
    .rf_wdata(rf_wdata), .rf_selected(rf_selected),
    .rf_lock_hit(rf_lock_hit), .rfcfg_en(rf_cfg_en), .auth_set(auth_set),
    .host_req(host_req), .host_we(host_we), .host_idx(host_idx),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .rf_done(rf_done),
    .rf_ack(rf_ack), .rf_mute(rf_mute), .rf_sleep(rf_sleep),
    .rf_zero_mask(rf_zero_mask), .rf_cfg_rdata(cfg_rdata), .eep_wr(eep_wr),
    .rf_authenticated(rf_auth), .rf_disabled(rf_dis),
    .tunnel_disabled(tun_dis), .sense_reply_high(sense_hi),
    .cc_value(cc_value));
  rpg_reader rdr (.clk_sys(clk_sys), .rf_done(rf_done),
    .ans({rf_ack, rf_mute, rf_sleep, rf_zero_mask}), .rf_op(rf_op),
    .rf_req(rf_req), .rf_addr(rf_addr), .rf_wdata(rf_wdata), .resp(resp));

  task automatic chk(input string nm, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic host(input logic w, input logic [3:0] i,
                      input logic [7:0] d);
    @(posedge clk_sys);
    host_req   <= 1'b1;
    host_we    <= w;
    host_idx   <= i;
    host_wdata <= d;
    @(posedge clk_sys);
    host_req   <= 1'b0;
    #1;
  endtask
  task automatic desel();
    @(posedge clk_sys);
    rf_selected <= 1'b0;
    @(posedge clk_sys);
    rf_selected <= 1'b1;
    #1;
  endtask
  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Delivery values, then container OR-write, password and protection.
  task automatic s_main();
    logic [7:0] ex [13] = '{8'h00, 8'h77, 8'hFF, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'hE1, 8'h10, 8'h3B, 8'h00};
    for (int k = 0; k < 13; k++) begin
      host(1'b0, 4'(k), 8'h00);
      chk("host byte", ex[k], host_rdata);
    end
    rdr.send(RPG_OP_WRITE, RPG_CC_BLK, 32'h0000_0100);
    chk("cc", 32'h003B_11E1, cc_value);
    rdr.send(RPG_OP_READ, 8'h2B, 32'h0);
    chk("pwd read", 7'h41, resp);
    rdr.send(RPG_OP_WRITE, 8'h2B, 32'h0000_0100);
    chk("bad pwd", 7'h30, resp);
    host(1'b0, RPG_CFG_RETRY, 8'h00);
    chk("retry dec", 8'h66, host_rdata);
    rdr.send(RPG_OP_WRITE, 8'h2B, 32'h0);
    chk("auth", 1'b1, rf_auth);
    host(1'b0, RPG_CFG_RETRY, 8'h00);
    chk("retry full", 8'h77, host_rdata);
    desel();
    chk("deselect", 1'b0, rf_auth);
    host(1'b1, RPG_CFG_LIMIT, 8'h10);
    host(1'b1, RPG_CFG_OPT, 8'h03);
    rdr.send(RPG_OP_READ, 8'h0F, 32'h0);
    chk("mixed read", 7'h4C, resp);
    rdr.send(RPG_OP_READ, 8'h20, 32'h0);
    chk("prot read", 7'h20, resp);
    host(1'b1, RPG_CFG_LIMIT, 8'h80);
    rdr.send(RPG_OP_READ, 8'h7E, 32'h0);
    chk("limit past end", 7'h40, resp);
  endtask

  // Config permission, password change, lock precedence, lockout, kill.
  task automatic s_lock();
    rdr.send(RPG_OP_WRITE, 8'h2B, 32'h0);
    rdr.send(RPG_OP_CFG_RD, {4'h0, RPG_CFG_LIMIT}, 32'h0);
    chk("cfg rd ack", 7'h40, resp);
    chk("cfg rd data", 8'h80, cfg_rdata);
    auth_set <= 1'b0;
    rdr.send(RPG_OP_CFG_RD, {4'h0, RPG_CFG_LIMIT}, 32'h0);
    chk("cfg rd refused", 7'h00, resp);
    auth_set <= 1'b1;
    rdr.send(RPG_OP_CFG_WR, {4'h0, RPG_CFG_SENSE_HI}, 32'h44);
    chk("sense wr", 8'h44, sense_hi);
    rf_cfg_en <= 1'b0;
    rdr.send(RPG_OP_CFG_WR, {4'h0, RPG_CFG_SENSE_HI}, 32'h11);
    chk("sense refused", 7'h00, resp);
    chk("sense kept", 8'h44, sense_hi);
    rf_cfg_en <= 1'b1;
    rdr.send(RPG_OP_WRITE, 8'h2B, 32'h1234_5678);
    host(1'b0, RPG_CFG_PWD0, 8'h00);
    chk("pwd change", 8'h78, host_rdata);
    rdr.send(RPG_OP_WRITE, 8'h05, 32'h0);
    chk("plain write", 1'b1, eep_wr);
    rf_lock_hit <= 1'b1;
    rdr.send(RPG_OP_WRITE, 8'h05, 32'h0);
    chk("locked write", 7'h00, resp);
    chk("locked no wr", 1'b0, eep_wr);
    rdr.send(RPG_OP_CFG_WR, 8'h00, 32'h0000_00C0);
    chk("rf kill write", 7'h00, resp);
    chk("rf kill kept", 1'b0, rf_dis);
    rf_lock_hit <= 1'b0;
    desel();
    host(1'b1, RPG_CFG_RETRY, 8'h70);
    rdr.send(RPG_OP_WRITE, 8'h2B, 32'h0);
    chk("lockout mute", 1'b1, resp[5]);
    chk("lockout auth", 1'b0, rf_auth);
    host(1'b0, RPG_CFG_RETRY, 8'h00);
    chk("lockout count", 8'h70, host_rdata);
    host(1'b1, RPG_CFG_KILL, 8'hC0);
    chk("killed", 1'b1, rf_dis);
    chk("tunnel killed", 1'b1, tun_dis);
    rdr.send(RPG_OP_READ, 8'h00, 32'h0);
    chk("killed mute", 1'b1, resp[5]);
  endtask

  // Clock, hang limit and main sequence.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    {arst_n, host_req, host_we, rf_lock_hit} = '0;
    {rf_cfg_en, auth_set} = 2'h3;
    {host_idx, host_wdata, rf_selected} = 13'h1;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    s_main();
    s_lock();
    conclude();
  end
endmodule
